//--- rtl/csa_arbiter.sv
// Operation
// RULE1: exactly one command and one speed source
// RULE2: reset defaults: terminal board, unipolar analog
// RULE3: override flag per source, scanned continuously
// RULE4: first flagged source wins, each path independent
// RULE5: no flags set: use primary settings
// RULE6: local mode flags two-wire, lights indicator
// RULE7: separate local-override prohibits for command, speed
// RULE8: communication flags stay until cleared or reset
// RULE9: terminal command override needs priority input, run
// RULE10: analog-terminal priority input selects voltage/current
// RULE11: reference-priority setting switches speed source
// RULE12: enabling special function replaces input's function
// RULE13: slow limits inputs three/four, stop five/six
// RULE14: creep, super creep, reference switch take four
// RULE15: speed-control mode chooses its used inputs
// RULE16: wizard accel and decel default ten seconds
// RULE17: autotune disabled or run on run command
// RULE18: fixed scan order forcing, comm, four-wire, keypad, terminal
// RULE19: serial/local switch input forces primary settings
// RULE20: primary command codes 0,2,3,4; 1 unused
// RULE21: selection registered once per scan pass
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`default_nettype none
module csa_arbiter (
  input  wire logic              I_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_CE,
  input  wire logic              I_HSEL,
  input  wire logic [31:0]       I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic [31:0]       I_HWDATA,
  input  wire logic              I_HREADY,
  output logic                   O_HREADYOUT,
  output logic [31:0]            O_HRDATA,
  output logic                   O_HRESP,
  input  wire logic [5:0]        I_DIN,
  input  wire logic              I_RUN,
  input  wire logic              I_LOCAL_MODE,
  output csa_pkg::csa_sel_t      O_SEL,
  output logic                   O_LOCAL_LED,
  output logic                   O_AUTOTUNE_REQ,
  output logic [7:0]             O_MODE_INPUTS
);
  // pin synchroniser chain: 6 discrete inputs, run, local mode
  logic [7:0]                 pin_s1_ff;   // first stage, feeds s2 only
  logic [7:0]                 pin_s2_ff;
  logic [7:0]                 pin_s3_ff;
  logic [7:0]                 pin_ff;      // accepted level
  logic [5:0]                 din;
  logic                       run;
  logic                       local_mode;
  logic                       run_d_ff;    // for run edge
  // registers
  logic [31:0]                ctrl_ff;
  logic [7:0]                 ovr_ff;
  logic [31:0]                wiz_ff;
  logic [15:0]                accel_ff;
  logic [15:0]                decel_ff;
  csa_pkg::csa_din_func_t     din_func_ff [csa_pkg::NUM_DIN];
  // bus state
  logic                       acc;
  logic                       wr_pend_ff;
  logic [7:0]                 wr_addr_ff;
  logic [31:0]                rd_val;
  // scan
  logic [15:0]                hit [csa_pkg::NUM_DIN];
  logic [15:0]                fn_act;      // functions currently active
  csa_pkg::csa_cmd_src_t      prim_cmd;
  csa_pkg::csa_spd_src_t      prim_spd;
  logic                       loc_cmd;
  logic                       loc_spd;
  csa_pkg::csa_sel_t          nxt_sel;
  csa_pkg::csa_sel_t          sel_ff;
  logic [7:0]                 nxt_mode_inputs;
  logic                       wiz_wr;
  assign din        = pin_ff[5:0];
  assign run        = pin_ff[6];
  assign local_mode = pin_ff[7];
  // three-stage sync; a change counts once stages two and three agree
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
      pin_s3_ff <= 8'h00;
      pin_ff    <= 8'h00;
    end else if (I_CE) begin
      pin_s1_ff <= {I_LOCAL_MODE, I_RUN, I_DIN};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
    end
  end
  // ahb-lite: zero wait while enabled; a frozen block stalls the bus
  assign O_HREADYOUT = I_CE;
  assign O_HRESP     = 1'b0;
  assign acc = I_CE && I_HSEL && I_HREADY && I_HTRANS[1];
  // write address held for the data phase
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else if (I_CE) begin
      wr_pend_ff <= acc && I_HWRITE;
      if (acc) begin
        wr_addr_ff <= I_HADDR[7:0];
      end
    end
  end
  // read mux; unmapped offsets read zero, status shows own state
  always_comb begin
    unique case (I_HADDR[7:0])
      csa_pkg::ADDR_CTRL:    rd_val = ctrl_ff;
      csa_pkg::ADDR_OVR_SET: rd_val = {24'h00_0000, ovr_ff};
      csa_pkg::ADDR_WIZ:     rd_val = wiz_ff;
      csa_pkg::ADDR_DIN_MAP: rd_val = {8'h00, din_func_ff[5], din_func_ff[4],
                                       din_func_ff[3], din_func_ff[2],
                                       din_func_ff[1], din_func_ff[0]};
      csa_pkg::ADDR_STATUS:  rd_val = {7'h00, run, O_MODE_INPUTS,
                                       7'h00, O_LOCAL_LED, 1'b0,
                                       sel_ff.cmd, sel_ff.spd};
      csa_pkg::ADDR_TIMES:   rd_val = {decel_ff, accel_ff};
      default:               rd_val = 32'h0000_0000;
    endcase
  end
  // read data captured at address phase, stands through data phase
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (I_CE && acc && !I_HWRITE) begin
      O_HRDATA <= rd_val;
    end
  end
  // control and timing settings
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_ff  <= csa_pkg::CTRL_RST;  // RULE2
      accel_ff <= csa_pkg::ACC_DEC_RST;  // RULE16
      decel_ff <= csa_pkg::ACC_DEC_RST;  // RULE16
    end else if (I_CE && wr_pend_ff) begin
      if (wr_addr_ff == csa_pkg::ADDR_CTRL) begin
        ctrl_ff <= I_HWDATA & csa_pkg::CTRL_MASK;
      end
      if (wr_addr_ff == csa_pkg::ADDR_TIMES) begin
        accel_ff <= I_HWDATA[15:0];
        decel_ff <= I_HWDATA[31:16];
      end
    end
  end
  // override flags: set and clear by writes, clear on reset, held otherwise
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ovr_ff <= csa_pkg::OVR_RST;  // RULE8
    end else if (I_CE && wr_pend_ff) begin
      if (wr_addr_ff == csa_pkg::ADDR_OVR_SET) begin
        ovr_ff <= ovr_ff | (I_HWDATA[7:0] & csa_pkg::OVR_MASK);  // RULE3
      end else if (wr_addr_ff == csa_pkg::ADDR_OVR_CLR) begin
        ovr_ff <= ovr_ff & ~I_HWDATA[7:0];  // RULE8
      end
    end
  end
  assign wiz_wr = I_CE && wr_pend_ff && (wr_addr_ff == csa_pkg::ADDR_WIZ);
  // wizard settings; autotune bit 0 = disabled, 1 = tune on run
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      wiz_ff <= csa_pkg::WIZ_RST;
    end else if (wiz_wr) begin
      wiz_ff <= I_HWDATA & csa_pkg::WIZ_MASK;  // RULE17
    end
  end
  // input function map; wizard enables overwrite, later ones win on four
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < csa_pkg::NUM_DIN; i++) begin
        din_func_ff[i] <= csa_pkg::FN_NONE;
      end
    end else if (I_CE && wr_pend_ff &&
                 wr_addr_ff == csa_pkg::ADDR_DIN_MAP) begin
      for (int i = 0; i < csa_pkg::NUM_DIN; i++) begin
        din_func_ff[i] <= csa_pkg::csa_din_func_t'(I_HWDATA[4*i +: 4]);
      end
    end else if (wiz_wr) begin
      if (I_HWDATA[csa_pkg::WIZ_SLOW]) begin  // RULE12
        din_func_ff[2] <= csa_pkg::FN_SLOW_FWD;  // RULE13
        din_func_ff[3] <= csa_pkg::FN_SLOW_REV;  // RULE13
      end
      if (I_HWDATA[csa_pkg::WIZ_STOP]) begin
        din_func_ff[4] <= csa_pkg::FN_STOP_FWD;  // RULE13
        din_func_ff[5] <= csa_pkg::FN_STOP_REV;  // RULE13
      end
      // creep, super creep, reference switch: last enabled keeps input four
      if (I_HWDATA[csa_pkg::WIZ_REF_SW]) begin
        din_func_ff[3] <= csa_pkg::FN_REF_SW;  // RULE14
      end else if (I_HWDATA[csa_pkg::WIZ_SUPER]) begin
        din_func_ff[3] <= csa_pkg::FN_SUPER_CREEP;  // RULE14
      end else if (I_HWDATA[csa_pkg::WIZ_CREEP]) begin
        din_func_ff[3] <= csa_pkg::FN_CREEP;  // RULE14
      end
    end
  end
  // per-input decode of the function an active input asserts
  generate
    for (genvar g = 0; g < csa_pkg::NUM_DIN; g++) begin : g_hit
      assign hit[g] = din[g] ? (16'h0001 << din_func_ff[g]) : 16'h0000;
    end
  endgenerate
  // any input carrying a function that is active
  always_comb begin
    fn_act = 16'h0000;
    for (int i = 0; i < csa_pkg::NUM_DIN; i++) begin
      fn_act = fn_act | hit[i];
    end
  end
  // primary settings; unused code 1 and codes above 4 fall to terminal
  always_comb begin
    unique case (ctrl_ff[csa_pkg::CTRL_CMD_LSB +: 3])
      3'h2:    prim_cmd = csa_pkg::CMD_KEYP;  // RULE20
      3'h3:    prim_cmd = csa_pkg::CMD_FOURW;  // RULE20
      3'h4:    prim_cmd = csa_pkg::CMD_COMM;  // RULE20
      default: prim_cmd = csa_pkg::CMD_TERM;  // RULE20
    endcase
    // reference priority may swap the primary speed source
    if (ctrl_ff[csa_pkg::CTRL_REF_PRIO] && fn_act[csa_pkg::FN_REF_SW]) begin
      prim_spd = csa_pkg::csa_spd_src_t'(
                 ctrl_ff[csa_pkg::CTRL_ALT_LSB +: 4]);  // RULE11
    end else begin
      prim_spd = csa_pkg::csa_spd_src_t'(
                 ctrl_ff[csa_pkg::CTRL_SPD_LSB +: 4]);
    end
  end
  // local mode flags two-wire unless prohibited per path
  assign loc_cmd = local_mode && !ctrl_ff[csa_pkg::CTRL_PROH_CMD];  // RULE7
  assign loc_spd = local_mode && !ctrl_ff[csa_pkg::CTRL_PROH_SPD];  // RULE7
  // one scan pass per cycle; command chain, then speed chain on its own;
  // if/else chains keep a single winner per path
  always_comb begin
    if (fn_act[csa_pkg::FN_SER_LOCAL]) begin
      nxt_sel.cmd = prim_cmd;  // RULE19
    end else if (ovr_ff[csa_pkg::OVR_CMD_COMM]) begin
      nxt_sel.cmd = csa_pkg::CMD_COMM;  // RULE18
    end else if (ovr_ff[csa_pkg::OVR_CMD_FOURW]) begin
      nxt_sel.cmd = csa_pkg::CMD_FOURW;  // RULE18
    end else if (loc_cmd) begin
      nxt_sel.cmd = csa_pkg::CMD_TWOW;  // RULE6
    end else if (ovr_ff[csa_pkg::OVR_CMD_KEYP]) begin
      nxt_sel.cmd = csa_pkg::CMD_KEYP;  // RULE4
    end else if (fn_act[csa_pkg::FN_CMD_PRIO] && run) begin
      nxt_sel.cmd = csa_pkg::CMD_TERM;  // RULE9
    end else begin
      nxt_sel.cmd = prim_cmd;  // RULE5
    end
    if (fn_act[csa_pkg::FN_SER_LOCAL]) begin
      nxt_sel.spd = prim_spd;  // RULE19
    end else if (ovr_ff[csa_pkg::OVR_SPD_COMM]) begin
      nxt_sel.spd = csa_pkg::SPD_COMM;  // RULE18
    end else if (ovr_ff[csa_pkg::OVR_SPD_FOURW]) begin
      nxt_sel.spd = csa_pkg::SPD_FOURW;  // RULE18
    end else if (loc_spd) begin
      nxt_sel.spd = csa_pkg::SPD_TWOW;  // RULE6
    end else if (ovr_ff[csa_pkg::OVR_SPD_KEYP]) begin
      nxt_sel.spd = csa_pkg::SPD_KEYP;  // RULE4
    end else if (fn_act[csa_pkg::FN_VI_PRIO]) begin
      nxt_sel.spd = csa_pkg::SPD_VI;  // RULE10
    end else begin
      nxt_sel.spd = prim_spd;  // RULE5
    end
  end
  // inputs used by the speed-control mode: [0] fwd [1] rev [7:2] in1..6
  always_comb begin
    unique case (wiz_ff[2:0])
      3'h0:    nxt_mode_inputs = 8'h07;  // RULE15
      3'h1:    nxt_mode_inputs = 8'h33;  // RULE15
      3'h2:    nxt_mode_inputs = 8'h3f;  // RULE15
      3'h3:    nxt_mode_inputs = 8'h07;
      3'h4:    nxt_mode_inputs = 8'h0f;
      default: nxt_mode_inputs = 8'h03;
    endcase
  end
  // registered selection and indicators
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sel_ff        <= csa_pkg::SEL_RST;  // RULE2
      O_LOCAL_LED   <= 1'b0;
      O_MODE_INPUTS <= 8'h07;
    end else if (I_CE) begin
      sel_ff        <= nxt_sel;  // RULE21
      O_LOCAL_LED   <= local_mode;  // RULE6
      O_MODE_INPUTS <= nxt_mode_inputs;
    end
  end
  assign O_SEL = sel_ff;  // RULE1
  // autotune request pulse on the rising run edge when enabled
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      run_d_ff       <= 1'b0;
      O_AUTOTUNE_REQ <= 1'b0;
    end else if (I_CE) begin
      run_d_ff       <= run;
      O_AUTOTUNE_REQ <= run && !run_d_ff &&
                        wiz_ff[csa_pkg::WIZ_AUTOTUNE];  // RULE17
    end
  end
  sequence s_set_wr;
    acc && I_HWRITE && I_HADDR[7:0] == csa_pkg::ADDR_OVR_SET ##1 I_CE;
  endsequence
  property p_reset_sel;
    @(posedge I_CLK) I_SYS_RST |=>
      O_SEL == csa_pkg::SEL_RST && ctrl_ff == csa_pkg::CTRL_RST;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("bad reset"); // RULE2
  property p_force;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      I_CE && fn_act[csa_pkg::FN_SER_LOCAL] |=> O_SEL.cmd == $past(prim_cmd);
  endproperty
  a_force: assert property (p_force) else $error("force lost"); // RULE19
  property p_comm;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      I_CE && !fn_act[csa_pkg::FN_SER_LOCAL] &&
      ovr_ff[csa_pkg::OVR_CMD_COMM] |=> O_SEL.cmd == csa_pkg::CMD_COMM;
  endproperty
  a_comm: assert property (p_comm) else $error("comm not first"); // RULE18
  property p_local;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      I_CE && !fn_act[csa_pkg::FN_SER_LOCAL] && ovr_ff[5:4] == 2'b00 &&
      loc_spd |=> O_SEL.spd == csa_pkg::SPD_TWOW && O_LOCAL_LED;
  endproperty
  a_local: assert property (p_local) else $error("local lost"); // RULE6
  property p_prim;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      I_CE && ovr_ff == 8'h00 && !local_mode && fn_act[3:1] == 3'b000
      |=> O_SEL.spd == $past(prim_spd) && O_SEL.cmd == $past(prim_cmd);
  endproperty
  a_prim: assert property (p_prim) else $error("primary lost"); // RULE5
  property p_ovr_set;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      s_set_wr |=> (ovr_ff & $past(I_HWDATA[7:0]) & csa_pkg::OVR_MASK)
                   == ($past(I_HWDATA[7:0]) & csa_pkg::OVR_MASK);
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("flag not set"); // RULE3
  property p_ovr_hold;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      ovr_ff[0] && !(wr_pend_ff && wr_addr_ff == csa_pkg::ADDR_OVR_CLR)
      |=> ovr_ff[0];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("flag dropped"); // RULE8
  property p_ref_sw;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      wiz_wr && I_HWDATA[csa_pkg::WIZ_REF_SW]
      |=> din_func_ff[3] == csa_pkg::FN_REF_SW;
  endproperty
  a_ref_sw: assert property (p_ref_sw) else $error("input four kept"); // RULE14
  property p_slow;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      wiz_wr && I_HWDATA[csa_pkg::WIZ_SLOW] && !I_HWDATA[15] &&
      I_HWDATA[13:12] == 2'b00 |=> din_func_ff[2] == csa_pkg::FN_SLOW_FWD
      && din_func_ff[3] == csa_pkg::FN_SLOW_REV;
  endproperty
  a_slow: assert property (p_slow) else $error("slow map bad"); // RULE13
  property p_vi;
    @(posedge I_CLK) disable iff (I_SYS_RST)
      I_CE && fn_act[csa_pkg::FN_VI_PRIO] && ovr_ff[6:4] == 3'b000 &&
      !loc_spd && !fn_act[csa_pkg::FN_SER_LOCAL]
      |=> O_SEL.spd == csa_pkg::SPD_VI;
  endproperty
  a_vi: assert property (p_vi) else $error("vi override lost"); // RULE10
endmodule
`default_nettype wire

//--- rtl/csa_pkg.sv
`default_nettype none
package csa_pkg;
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_OVR_SET = 8'h04;
  localparam logic [7:0]  ADDR_OVR_CLR = 8'h08;
  localparam logic [7:0]  ADDR_WIZ     = 8'h0c;
  localparam logic [7:0]  ADDR_DIN_MAP = 8'h10;
  localparam logic [7:0]  ADDR_STATUS  = 8'h14;
  localparam logic [7:0]  ADDR_TIMES   = 8'h18;
  // ctrl fields
  localparam int          CTRL_CMD_LSB    = 0;
  localparam int          CTRL_SPD_LSB    = 4;
  localparam int          CTRL_PROH_CMD   = 8;
  localparam int          CTRL_PROH_SPD   = 9;
  localparam int          CTRL_REF_PRIO   = 10;
  localparam int          CTRL_ALT_LSB    = 12;
  localparam logic [31:0] CTRL_RST        = 32'h0000_1020;
  localparam logic [31:0] CTRL_MASK       = 32'h0000_f7f7;
  // override flag bits
  localparam int          OVR_CMD_COMM  = 0;
  localparam int          OVR_CMD_FOURW = 1;
  localparam int          OVR_CMD_KEYP  = 2;
  localparam int          OVR_SPD_COMM  = 4;
  localparam int          OVR_SPD_FOURW = 5;
  localparam int          OVR_SPD_KEYP  = 6;
  localparam logic [7:0]  OVR_MASK      = 8'h77;
  localparam logic [7:0]  OVR_RST       = 8'h00;
  // wizard fields
  localparam int          WIZ_SLOW     = 8;
  localparam int          WIZ_STOP     = 9;
  localparam int          WIZ_CREEP    = 12;
  localparam int          WIZ_SUPER    = 13;
  localparam int          WIZ_REF_SW   = 15;
  localparam int          WIZ_AUTOTUNE = 16;
  localparam logic [31:0] WIZ_MASK     = 32'h0001_ff07;
  localparam logic [31:0] WIZ_RST      = 32'h0000_0000;
  // wizard default accel/decel, tenths of a second (10.0 s)
  localparam logic [15:0] ACC_DEC_RST  = 16'h0064;
  localparam int          NUM_DIN      = 6;

  // command sources, primary setting encoding plus the two-wire port
  typedef enum logic [2:0] {
    CMD_TERM  = 3'h0,
    CMD_KEYP  = 3'h2,
    CMD_FOURW = 3'h3,
    CMD_COMM  = 3'h4,
    CMD_TWOW  = 3'h5
  } csa_cmd_src_t;
  // speed-reference sources
  typedef enum logic [3:0] {
    SPD_VI    = 4'h1,
    SPD_RR    = 4'h2,
    SPD_RX    = 4'h3,
    SPD_KEYP  = 4'h5,
    SPD_FOURW = 4'h6,
    SPD_COMM  = 4'h7,
    SPD_TWOW  = 4'he
  } csa_spd_src_t;
  // functions a discrete input can carry
  typedef enum logic [3:0] {
    FN_NONE = 4'h0, FN_SER_LOCAL = 4'h1, FN_CMD_PRIO = 4'h2,
    FN_VI_PRIO = 4'h3, FN_SLOW_FWD = 4'h4, FN_SLOW_REV = 4'h5,
    FN_STOP_FWD = 4'h6, FN_STOP_REV = 4'h7, FN_CREEP = 4'h8,
    FN_SUPER_CREEP = 4'h9, FN_REF_SW = 4'ha
  } csa_din_func_t;
  // selected sources travel together
  typedef struct packed {
    csa_cmd_src_t cmd;
    csa_spd_src_t spd;
  } csa_sel_t;
  localparam csa_sel_t SEL_RST = '{cmd: CMD_TERM, spd: SPD_RR};
endpackage
`default_nettype wire

//--- verif/csa_arbiter_tb_top.sv
`default_nettype none
module csa_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;      // 100 mhz
  logic              rst = 1'b1;      // sync reset
  logic              ce = 1'b1;       // clock enable
  logic              hsel = 1'b0;     // bus select
  logic [31:0]       haddr = 32'h0;   // bus address
  logic [1:0]        htrans = 2'h0;   // bus transfer kind
  logic              hwrite = 1'b0;   // bus direction
  logic [31:0]       hwdata = 32'h0;  // bus write data
  logic              hrdy;            // slave ready is bus ready
  logic [31:0]       hrdata;          // bus read data
  logic              hresp;           // bus response
  logic [5:0]        din_q = 6'h00;   // requested pin levels
  logic              run_q = 1'b0;    // requested run
  logic              loc_q = 1'b0;    // requested local key
  wire  logic [5:0]  din;             // pins from model
  wire  logic        run;             // run pin
  wire  logic        loc;             // local pin
  csa_pkg::csa_sel_t sel;             // selected sources
  logic              led;             // local indicator
  logic              atune;           // autotune pulse
  logic [7:0]        modein;          // inputs used by mode
  int                err_count = 0;   // mismatches
  int                tests_run = 0;   // comparisons
  logic [31:0]       v;               // scratch read value
  int                k;               // pulse count
  logic [2:0]        cmds[4] = '{3'h0, 3'h2, 3'h3, 3'h4};
  logic [3:0]        spds[4] = '{4'h1, 4'h3, 4'h5, 4'h6};
  logic [7:0]        mexp[3] = '{8'h07, 8'h33, 8'h3f};
  logic [31:0]       wfn[3] = '{32'h1100, 32'h2100, 32'h8100};

  always #5 clk = ~clk;

  csa_arbiter u_dut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HREADYOUT(hrdy), .O_HRDATA(hrdata), .O_HRESP(hresp),
    .I_DIN(din), .I_RUN(run), .I_LOCAL_MODE(loc), .O_SEL(sel),
    .O_LOCAL_LED(led), .O_AUTOTUNE_REQ(atune), .O_MODE_INPUTS(modein)
  );
  csa_src_model u_src (
    .i_clk(clk), .i_din_req(din_q), .i_run_req(run_q),
    .i_local_req(loc_q), .o_din(din), .o_run(run), .o_local(loc)
  );

  // closing report, one place only
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // step just past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait for ready with a bound; a hang ends the run
  task automatic rdy_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      err_count++;
      print_verdict();
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy_wait();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy_wait();
    rd = hrdata;
  endtask
  // write, then let the selection register follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
    wt(2);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic chksel(input logic [2:0] c, input logic [3:0] s);
    chk({25'h0, sel}, {25'h0, c, s});
  endtask
  // pins pass a three-stage sync, so allow six edges to settle
  task automatic pins(input logic [5:0] d, input logic r, input logic l);
    @(posedge clk);
    din_q <= d;
    run_q <= r;
    loc_q <= l;
    wt(6);
  endtask
  task automatic pulses;
    k = 0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (atune === 1'b1) k++;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chksel(3'h0, 4'h2);
    chk({31'h0, led}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rdchk(csa_pkg::ADDR_CTRL, 32'h1020);
    rdchk(csa_pkg::ADDR_TIMES, 32'h0064_0064);
    rdchk(8'h1c, 32'h0);
    // every legal primary code, then the unused one
    for (int i = 0; i < 4; i++) begin
      wr(csa_pkg::ADDR_CTRL, {24'h0, spds[i], 1'b0, cmds[i]});
      chksel(cmds[i], spds[i]);
    end
    wr(csa_pkg::ADDR_CTRL, 32'h0021);
    chksel(3'h0, 4'h2);
    // stacked flags: the higher source must win each time
    wr(csa_pkg::ADDR_OVR_SET, 32'h44);
    chksel(3'h2, 4'h5);
    wr(csa_pkg::ADDR_OVR_SET, 32'h22);
    chksel(3'h3, 4'h6);
    wr(csa_pkg::ADDR_OVR_SET, 32'h11);
    chksel(3'h4, 4'h7);
    rdchk(csa_pkg::ADDR_OVR_SET, 32'h77);
    wr(csa_pkg::ADDR_OVR_CLR, 32'h11);
    chksel(3'h3, 4'h6);
    rdchk(csa_pkg::ADDR_OVR_CLR, 32'h0);
    // local key under a four-wire flag, then over the keypad flag
    pins(6'h00, 1'b0, 1'b1);
    chksel(3'h3, 4'h6);
    chk({31'h0, led}, 32'h1);
    wr(csa_pkg::ADDR_OVR_CLR, 32'h22);
    chksel(3'h5, 4'he);
    wr(csa_pkg::ADDR_CTRL, 32'h0120);
    chksel(3'h2, 4'he);
    wr(csa_pkg::ADDR_CTRL, 32'h0220);
    chksel(3'h5, 4'h5);
    wr(csa_pkg::ADDR_OVR_CLR, 32'h77);
    wr(csa_pkg::ADDR_CTRL, 32'h0052);
    pins(6'h00, 1'b0, 1'b0);
    chksel(3'h2, 4'h5);
    // in1 cmd prio, in2 v/i prio, in3 serial/local, in4 ref switch
    wr(csa_pkg::ADDR_DIN_MAP, 32'ha132);
    pins(6'h02, 1'b0, 1'b0);
    chksel(3'h2, 4'h1);
    pins(6'h03, 1'b0, 1'b0);
    chksel(3'h2, 4'h1);
    pins(6'h03, 1'b1, 1'b0);
    chksel(3'h0, 4'h1);
    wr(csa_pkg::ADDR_OVR_SET, 32'h11);
    pins(6'h07, 1'b1, 1'b0);
    chksel(3'h2, 4'h5);
    wr(csa_pkg::ADDR_OVR_CLR, 32'h77);
    wr(csa_pkg::ADDR_CTRL, 32'h3452);
    pins(6'h00, 1'b0, 1'b0);
    chksel(3'h2, 4'h5);
    pins(6'h08, 1'b0, 1'b0);
    chksel(3'h2, 4'h3);
    rdchk(csa_pkg::ADDR_STATUS, 32'h0007_0023);
    // a frozen block ignores a pin change and stalls the bus
    @(posedge clk);
    ce <= 1'b0;
    din_q <= 6'h00;
    wt(8);
    chksel(3'h2, 4'h3);
    chk({31'h0, hrdy}, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    pins(6'h00, 1'b0, 1'b0);
    // wizard remaps the limit and creep inputs
    wr(csa_pkg::ADDR_WIZ, 32'h0300);
    rdchk(csa_pkg::ADDR_DIN_MAP, 32'h0076_5432);
    for (int i = 0; i < 3; i++) begin
      wr(csa_pkg::ADDR_DIN_MAP, 32'h0032);
      wr(csa_pkg::ADDR_WIZ, wfn[i]);
      rdchk(csa_pkg::ADDR_DIN_MAP, {16'h0, 4'h8 + i[3:0], 12'h432});
    end
    for (int i = 0; i < 3; i++) begin
      wr(csa_pkg::ADDR_WIZ, i);
      chk({24'h0, modein}, {24'h0, mexp[i]});
    end
    wr(csa_pkg::ADDR_WIZ, 32'h1_0000);
    @(posedge clk);
    run_q <= 1'b1;
    pulses();
    chk(k, 32'h1);
    wr(csa_pkg::ADDR_WIZ, 32'h0);
    pins(6'h00, 1'b0, 1'b0);
    @(posedge clk);
    run_q <= 1'b1;
    pulses();
    chk(k, 32'h0);
    // a reset in mid-run drops a flag set over the bus
    wr(csa_pkg::ADDR_OVR_SET, 32'h11);
    chksel(3'h4, 4'h7);
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chksel(3'h0, 4'h2);
    rdchk(csa_pkg::ADDR_OVR_SET, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verif/csa_src_model.sv
`default_nettype none
// far-side sources: terminal board pins, run command, panel local key
module csa_src_model (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_din_req,
  input  wire logic       i_run_req,
  input  wire logic       i_local_req,
  output var  logic [5:0] o_din,
  output var  logic       o_run,
  output var  logic       o_local
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, like a real contact closing;
  // unknown only before the first edge, well inside the bench's reset
  always @(posedge i_clk) begin
    o_din   <= i_din_req;
    o_run   <= i_run_req;
    o_local <= i_local_req;
  end
endmodule
`default_nettype wire
